// ==== inc/rail_enable_consts.svh ====
// Purpose: constants for the rail enable sequencing block
// Assumes: byte address of a register is four times its index
// Notes: reserved bits are never stored and read as zero
`ifndef RAIL_ENABLE_CONSTS_SVH
`define RAIL_ENABLE_CONSTS_SVH
// register indices
`define IDX_SIX_DELAY 6'h18
`define IDX_MASK_A 6'h19
`define IDX_MASK_B 6'h1A
`define IDX_LS_DELAY 6'h1B
`define IDX_STATUS 6'h20
// writable bits per register
`define RW_MASK_A 8'hFF
`define RW_MASK_B 8'h7F
`define RW_LS_DELAY 8'h7F
`define RW_SIX_DELAY 8'h3F
// reset values
`define RST_MASK_A 8'h00
`define RST_MASK_B 8'h00
`define RST_LS_DELAY 8'h00
`define RST_SIX_DELAY 8'h00
// field positions
`define SRC_MSB 4
`define SRC_LSB 2
`define THR_MSB 6
`define THR_LSB 5
`define TERM_SEL_BIT 6
`define ON_MSB 2
`define ON_LSB 0
`define OFF_MSB 5
`define OFF_LSB 3
// enable source codes
`define SRC_ONE 3'h0
`define SRC_TWO 3'h1
`define SRC_FIVE 3'h2
`define SRC_FOUR 3'h3
`define SRC_THREE 3'h4
`define SRC_THREE_FOUR 3'h5
`define SRC_SIX 3'h6
`define SRC_FORCED 3'h7
// delay steps in milliseconds
`define DLY_0 7'h00
`define DLY_1 7'h02
`define DLY_2 7'h04
`define DLY_3 7'h08
`define DLY_4 7'h10
`define DLY_5 7'h18
`define DLY_6 7'h20
`define DLY_7 7'h40
// timing
`define CLK_PERIOD_NS 8
`define NS_PER_MS 1000000
`define DELAY_UNIT_MS 1
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== inc/rail_enable_pkg.sv ====
// Purpose: types and shared decode for the rail enable sequencing block
// Assumes: constants header is on the include path
// Notes: control inputs are indexed from zero, input one at bit 0
package rail_enable_pkg;
`include "rail_enable_consts.svh"

    // software visible configuration
    typedef struct packed {
        logic [7:0] six_delay;
        logic [7:0] mask_a;
        logic [7:0] mask_b;
        logic [7:0] ls_delay;
    } regs_t;

    // state of one edge delay timer
    typedef struct packed {
        logic out;
        logic [16:0] pre;
        logic [6:0] ms;
    } delay_st_t;

    // state of the top level
    typedef struct packed {
        regs_t regs;
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] sync3;
        logic [15:0] filt;
        logic aw_held;
        logic [5:0] aw_idx;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic raw_en;
        logic term_en;
    } rail_st_t;

    // eight step delay code to milliseconds
    function automatic logic [6:0] delay_ms(input logic [2:0] code);
        case (code)
            3'h0: delay_ms = `DLY_0;
            3'h1: delay_ms = `DLY_1;
            3'h2: delay_ms = `DLY_2;
            3'h3: delay_ms = `DLY_3;
            3'h4: delay_ms = `DLY_4;
            3'h5: delay_ms = `DLY_5;
            3'h6: delay_ms = `DLY_6;
            default: delay_ms = `DLY_7;
        endcase
    endfunction

    // enable source selector over the six control inputs
    function automatic logic select_source(input logic [2:0] src, input logic [5:0] ctl);
        case (src)
            `SRC_ONE: select_source = ctl[0];
            `SRC_TWO: select_source = ctl[1];
            `SRC_FIVE: select_source = ctl[4];
            `SRC_FOUR: select_source = ctl[3];
            `SRC_THREE: select_source = ctl[2];
            `SRC_THREE_FOUR: select_source = ctl[2] & ctl[3];
            `SRC_SIX: select_source = ctl[5];
            default: select_source = 1'b1;
        endcase
    endfunction
endpackage

// ==== hw/edge_delay.sv ====
// Purpose: delays rising and falling edges of one enable by a coded time
// Assumes: raw comes from logic on aclk
// Notes: prescaler restarts with each pending edge, so delays are exact
`timescale 1ns/1ps
module edge_delay #(
    parameter int unsigned TICK_CYCLES = 125000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic raw,
    input wire logic [2:0] on_code,
    input wire logic [2:0] off_code,
    output logic delayed
);
    import rail_enable_pkg::*;

    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

    delay_st_t st; // registered state
    delay_st_t next_st; // next state
    logic [6:0] target; // wait for the pending edge in ms

    // rising edge uses the on code, falling edge the off code
    assign target = delay_ms(st.out ? off_code : on_code);
    assign delayed = st.out;

    // timer: a withdrawn edge clears the count, so a new one starts over
    always_comb begin
        next_st = st;
        if (raw == st.out) begin
            next_st.pre = 17'h0; // settled or edge withdrawn
            next_st.ms = 7'h00;
        end else if (target == 7'h00 || st.ms == target) begin
            next_st.out = raw; // edge released
            next_st.pre = 17'h0;
            next_st.ms = 7'h00;
        end else if (st.pre == TICK_LAST) begin
            next_st.pre = 17'h0; // one millisecond elapsed
            next_st.ms = st.ms + 7'h01;
        end else begin
            next_st.pre = st.pre + 17'h1;
        end
    end

    // state register, synchronous reset to disabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    property p_settled_clear;
        @(posedge aclk) disable iff (!aresetn)
        (raw == st.out) |=> (st.ms == 7'h00 && st.pre == 17'h0);
    endproperty
    a_settled_clear: assert property (p_settled_clear)
        else $error("timer not cleared while settled");

    property p_moves_to_raw;
        @(posedge aclk) disable iff (!aresetn)
        $changed(st.out) |-> (st.out == $past(raw));
    endproperty
    a_moves_to_raw: assert property (p_moves_to_raw)
        else $error("output moved away from input");

    property p_zero_immediate;
        @(posedge aclk) disable iff (!aresetn)
        (raw != st.out && target == 7'h00) |=> (st.out == $past(raw));
    endproperty
    a_zero_immediate: assert property (p_zero_immediate)
        else $error("zero delay edge not passed at once");

    property p_full_wait;
        @(posedge aclk) disable iff (!aresetn)
        ($changed(st.out) && $past(target) != 7'h00) |-> ($past(st.ms) == $past(target));
    endproperty
    a_full_wait: assert property (p_full_wait)
        else $error("edge released before programmed delay");
endmodule

// ==== hw/rail_enable_sequencing.sv ====
// Purpose: enable control of the load switch rail and rail six edge delays
// Assumes: AXI4-Lite master keeps one write and one read outstanding
// Notes: pins pass three flops; a change counts once stages two and three agree
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module rail_enable_sequencing #(
    parameter int unsigned TICK_CYCLES = (`DELAY_UNIT_MS * `NS_PER_MS) / `CLK_PERIOD_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [5:0] control_input,
    input wire logic [9:0] rail_in_regulation,
    input wire logic rail_six_enable_request,
    output logic load_switch_rail_enable,
    output logic step_down_rail_six_enable,
    output logic ddr_termination_enable,
    output logic [1:0] load_switch_good_threshold
);
    import rail_enable_pkg::*;

    // reset image: configuration at its reset values, all else clear
    localparam rail_st_t RST_ST = '{
        regs: '{
            six_delay: `RST_SIX_DELAY,
            mask_a: `RST_MASK_A,
            mask_b: `RST_MASK_B,
            ls_delay: `RST_LS_DELAY
        },
        default: '0
    };

    rail_st_t st; // all registered state
    rail_st_t next_st; // next value of the state
    logic [5:0] ctl; // filtered control inputs
    logic [9:0] good; // filtered rail good levels
    logic [9:0] good_mask; // one drops a good term
    logic sel; // selector output
    logic good_ok; // every kept good term is high
    logic [2:0] src; // enable source field
    logic [7:0] read_word; // readback of the addressed register

    // filtered views: low six bits are the control inputs
    assign ctl = st.filt[5:0];
    assign good = st.filt[15:6];
    // bits 7..0 from first mask register, 9..8 from second
    assign good_mask = {st.regs.mask_b[1:0], st.regs.mask_a};
    assign src = st.regs.mask_b[`SRC_MSB:`SRC_LSB];
    // code seven yields a constant one inside the selector
    assign sel = select_source(src, ctl);
    // a set mask bit forces its term true
    assign good_ok = &(good | good_mask);

    // handshake outputs straight from the state
    assign s_axi_awready = !st.aw_held && !st.bvalid;
    assign s_axi_wready = !st.w_held && !st.bvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = {24'h000000, st.rdata};
    assign ddr_termination_enable = st.term_en;
    assign load_switch_good_threshold = st.regs.mask_b[`THR_MSB:`THR_LSB];

    // readback decode, unmapped reads return zero
    always_comb begin
        if (s_axi_araddr[7:2] == `IDX_SIX_DELAY) begin
            read_word = st.regs.six_delay;
        end else if (s_axi_araddr[7:2] == `IDX_MASK_A) begin
            read_word = st.regs.mask_a;
        end else if (s_axi_araddr[7:2] == `IDX_MASK_B) begin
            read_word = st.regs.mask_b;
        end else if (s_axi_araddr[7:2] == `IDX_LS_DELAY) begin
            read_word = st.regs.ls_delay;
        end else if (s_axi_araddr[7:2] == `IDX_STATUS) begin
            // live view of the three driven enables and the undelayed enable
            read_word = {4'h0, st.term_en, step_down_rail_six_enable,
                load_switch_rail_enable, st.raw_en};
        end else begin
            read_word = 8'h00;
        end
    end

    // next state: synchronisers, enable logic, bus slave
    always_comb begin
        next_st = st;
        // first stage feeds only the second stage
        next_st.sync1 = {rail_in_regulation, control_input};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        // bits where stages two and three agree take the new level
        next_st.filt = (~(st.sync2 ^ st.sync3) & st.sync3)
            | ((st.sync2 ^ st.sync3) & st.filt);
        // undelayed enable, gated by the kept good terms
        next_st.raw_en = sel & good_ok;
        // termination enable follows input three or input six
        next_st.term_en = st.regs.ls_delay[`TERM_SEL_BIT] ? ctl[5] : ctl[2];

        // write address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_idx = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        // both halves held: commit and answer
        if (st.aw_held && st.w_held) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `RESP_OKAY;
            // only byte lane zero carries register bits
            if (st.aw_idx == `IDX_SIX_DELAY) begin
                if (st.w_lane0) begin
                    next_st.regs.six_delay = st.w_data & `RW_SIX_DELAY;
                end
            end else if (st.aw_idx == `IDX_MASK_A) begin
                if (st.w_lane0) begin
                    next_st.regs.mask_a = st.w_data & `RW_MASK_A;
                end
            end else if (st.aw_idx == `IDX_MASK_B) begin
                if (st.w_lane0) begin
                    next_st.regs.mask_b = st.w_data & `RW_MASK_B;
                end
            end else if (st.aw_idx == `IDX_LS_DELAY) begin
                if (st.w_lane0) begin
                    next_st.regs.ls_delay = st.w_data & `RW_LS_DELAY;
                end
            end else if (st.aw_idx == `IDX_STATUS) begin
                // status is read only, write ignored
                next_st.bresp = `RESP_OKAY;
            end else begin
                // nothing here: flag the master
                next_st.bresp = `RESP_SLVERR;
            end
        end
        // response retires when taken
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // read: data is ready one cycle after the address
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = read_word;
            if (s_axi_araddr[7:2] == `IDX_SIX_DELAY || s_axi_araddr[7:2] == `IDX_MASK_A
                || s_axi_araddr[7:2] == `IDX_MASK_B || s_axi_araddr[7:2] == `IDX_LS_DELAY
                || s_axi_araddr[7:2] == `IDX_STATUS) begin
                next_st.rresp = `RESP_OKAY;
            end else begin
                next_st.rresp = `RESP_SLVERR;
            end
        end
    end

    // state register, synchronous active low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= RST_ST;
        end else begin
            st <= next_st;
        end
    end

    // load switch rail edge delays
    edge_delay #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_switch_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw(st.raw_en),
        .on_code(st.regs.ls_delay[`ON_MSB:`ON_LSB]),
        .off_code(st.regs.ls_delay[`OFF_MSB:`OFF_LSB]),
        .delayed(load_switch_rail_enable)
    );

    // rail six edge delays; its undelayed enable comes from elsewhere
    edge_delay #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_six_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw(rail_six_enable_request),
        .on_code(st.regs.six_delay[`ON_MSB:`ON_LSB]),
        .off_code(st.regs.six_delay[`OFF_MSB:`OFF_LSB]),
        .delayed(step_down_rail_six_enable)
    );

    property p_forced_on;
        @(posedge aclk) disable iff (!aresetn)
        (src == `SRC_FORCED && good_ok) |=> st.raw_en;
    endproperty
    a_forced_on: assert property (p_forced_on)
        else $error("forced source did not enable");

    property p_source_map;
        @(posedge aclk) disable iff (!aresetn)
        (src == `SRC_FIVE |-> sel == ctl[4])
            and (src == `SRC_THREE |-> sel == ctl[2])
            and (src == `SRC_THREE_FOUR |-> sel == (ctl[2] & ctl[3]));
    endproperty
    a_source_map: assert property (p_source_map)
        else $error("selector picked the wrong input");

    property p_enable_cause;
        @(posedge aclk) disable iff (!aresetn)
        $rose(st.raw_en) |-> ($past(sel) && $past(good_ok));
    endproperty
    a_enable_cause: assert property (p_enable_cause)
        else $error("enable rose without source and goods");

    property p_kept_term_blocks;
        @(posedge aclk) disable iff (!aresetn)
        (|(~good & ~good_mask)) |=> !st.raw_en;
    endproperty
    a_kept_term_blocks: assert property (p_kept_term_blocks)
        else $error("unmasked low good did not block enable");

    property p_linear_three;
        @(posedge aclk) disable iff (!aresetn)
        (!st.regs.mask_a[7] && !good[7]) |=> !st.raw_en;
    endproperty
    a_linear_three: assert property (p_linear_three)
        else $error("linear three good ignored");

    property p_switch_one;
        @(posedge aclk) disable iff (!aresetn)
        (!st.regs.mask_b[0] && !good[8]) |=> !st.raw_en;
    endproperty
    a_switch_one: assert property (p_switch_one)
        else $error("switch one good ignored");

    property p_term_source;
        @(posedge aclk) disable iff (!aresetn)
        ##1 (ddr_termination_enable
            == $past(st.regs.ls_delay[`TERM_SEL_BIT] ? ctl[5] : ctl[2]));
    endproperty
    a_term_source: assert property (p_term_source)
        else $error("termination enable from wrong input");

    property p_threshold_write;
        @(posedge aclk) disable iff (!aresetn)
        $changed(load_switch_good_threshold) |-> $rose(s_axi_bvalid);
    endproperty
    a_threshold_write: assert property (p_threshold_write)
        else $error("threshold changed without a write");

    property p_bvalid_hold;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold)
        else $error("write response dropped before taken");
endmodule

// ==== bench/host_pins.sv ====
// Purpose: far side model, a host driving control pins and rail good levels
// Assumes: bench sets want values just after a rising edge
// Notes: one register stage of lag, like a host gpio launched on its own flop
`timescale 1ns/1ps
module host_pins (
    input wire logic aclk,
    input wire logic [5:0] want_ctl,
    input wire logic [9:0] want_good,
    output logic [5:0] control_input,
    output logic [9:0] rail_in_regulation
);
    // pins start with every rail good and no control asserted
    logic [15:0] held = 16'hFFC0;

    // host relaunches its pins on each edge, so the pins are never unknown
    always @(posedge aclk) begin
        held <= {want_good, want_ctl};
    end

    assign {rail_in_regulation, control_input} = held;
endmodule

// ==== bench/tb_top.sv ====
// Purpose: self checking bench for the rail enable sequencing block
// Assumes: short tick of four cycles stands for one millisecond
// Notes: delays are measured in edges; load switch ones relative to a zero code baseline, rail six ones as code time plus one edge
`timescale 1ns/1ps
module tb_top;
    import rail_enable_pkg::*;
    localparam int unsigned TICK = 4; // short tick keeps the run brief
    localparam logic [7:0] IDX_SIX = 8'h18; // register indices
    localparam logic [7:0] IDX_A = 8'h19;
    localparam logic [7:0] IDX_B = 8'h1A;
    localparam logic [7:0] IDX_LS = 8'h1B;
    localparam int MS [8] = '{0, 2, 4, 8, 16, 24, 32, 64}; // step times
    logic aclk, aresetn;
    logic [7:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata, rdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, thr;
    logic [5:0] pin_ctl, ctl;
    logic [9:0] pin_good, good;
    logic six_req, ls_en, six_en, term_en;
    int err_count, n_tests;

    host_pins i_host_pins (.aclk(aclk), .want_ctl(pin_ctl), .want_good(pin_good),
        .control_input(ctl), .rail_in_regulation(good));

    rail_enable_sequencing #(.TICK_CYCLES(TICK)) i_rail_enable_sequencing (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .control_input(ctl),
        .rail_in_regulation(good), .rail_six_enable_request(six_req),
        .load_switch_rail_enable(ls_en), .step_down_rail_six_enable(six_en),
        .ddr_termination_enable(term_en), .load_switch_good_threshold(thr));

    // free running clock, 8 ns period
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // one compare, counted; mismatch reported at once
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict in one place
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // register write by index; channels released only at their own handshake
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] exp);
        bit aw_p, w_p, ta, tw;
        logic [1:0] r;
        awaddr <= idx << 2;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_p = 1;
        w_p = 1;
        while (aw_p || w_p) begin
            @(negedge aclk);
            ta = aw_p && (awready === 1'b1);
            tw = w_p && (wready === 1'b1);
            @(posedge aclk);
            if (ta) begin
                awvalid <= 1'b0;
                aw_p = 0;
            end
            if (tw) begin
                wvalid <= 1'b0;
                w_p = 0;
            end
        end
        ta = 0;
        while (!ta) begin
            @(negedge aclk);
            ta = (bvalid === 1'b1);
            r = bresp;
            @(posedge aclk);
        end
        bready <= 1'b0;
        // let an edge pass so a following call never drives bready twice in one step
        @(posedge aclk);
        chk("bresp", {30'h0, r}, {30'h0, exp});
    endtask

    // register read by index; data and response taken with the answer
    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        bit ta;
        araddr <= idx << 2;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ta = 0;
        while (!ta) begin
            @(negedge aclk);
            ta = (arready === 1'b1);
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        ta = 0;
        while (!ta) begin
            @(negedge aclk);
            ta = (rvalid === 1'b1);
            d = rdata;
            r = rresp;
            @(posedge aclk);
        end
        rready <= 1'b0;
        // let an edge pass so a following call never drives rready twice in one step
        @(posedge aclk);
    endtask

    // pins need sync, filter and registering before they show
    task automatic settle();
        repeat (10) @(posedge aclk);
        #1;
    endtask

    // edges until one enable output reaches the wanted level
    task automatic lat(input bit six, input logic want, output int n);
        n = 0;
        do begin
            @(posedge aclk);
            #1;
            n++;
        end while (((six ? six_en : ls_en) !== want) && n < 2000);
    endtask

    // reset values, writable bits, status, unmapped place
    task automatic s_regs();
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] ix [4] = '{IDX_SIX, IDX_A, IDX_B, IDX_LS};
        logic [7:0] rw [4] = '{8'h3F, 8'hFF, 8'h7F, 8'h7F}; // reserved bits read zero
        for (int i = 0; i < 4; i++) begin
            rd(ix[i], d, r);
            chk("reset value", d, 32'h0);
            chk("mapped resp", {30'h0, r}, 32'h0);
            wr(ix[i], 8'hFF, 2'h0);
            rd(ix[i], d, r);
            chk("writable bits", d, {24'h0, rw[i]});
            wr(ix[i], 8'h00, 2'h0);
        end
        wr(8'h20, 8'hFF, 2'h0);
        wr(8'h24, 8'h55, 2'h2);
        rd(8'h24, d, r);
        chk("unmapped resp", {30'h0, r}, 32'h2);
        chk("unmapped data", d, 32'h0);
    endtask

    // every source code, awkward case of inputs three and four apart
    task automatic s_source();
        logic [5:0] sel [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};
        for (int c = 0; c < 8; c++) begin
            wr(IDX_B, {3'h0, c[2:0], 2'h0}, 2'h0);
            pin_ctl <= sel[c];
            settle();
            chk("source on", ls_en, 1'b1);
            pin_ctl <= (c == 5) ? 6'h04 : ~sel[c];
            settle();
            chk("source off", ls_en, c == 7);
        end
        pin_ctl <= 6'h00;
    endtask

    // each good term gates the enable until its own mask bit drops it
    task automatic s_mask();
        for (int g = 0; g < 10; g++) begin
            pin_good <= ~(10'h001 << g);
            settle();
            chk("good gates", ls_en, 1'b0);
            if (g < 8) begin
                wr(IDX_A, 8'h01 << g, 2'h0);
            end else begin
                wr(IDX_B, 8'h1C | (8'h01 << (g - 8)), 2'h0);
            end
            settle();
            chk("good masked", ls_en, 1'b1);
            wr(IDX_A, 8'h00, 2'h0);
            wr(IDX_B, 8'h1C, 2'h0);
        end
        pin_good <= 10'h3FF;
    endtask

    // threshold field and termination source
    task automatic s_misc();
        logic [31:0] d;
        logic [1:0] r;
        for (int t = 0; t < 4; t++) begin
            wr(IDX_B, {1'b0, t[1:0], 5'h00}, 2'h0);
            chk("threshold", thr, t[1:0]);
        end
        for (int s = 0; s < 2; s++) begin
            wr(IDX_LS, {1'b0, s[0], 6'h00}, 2'h0);
            pin_ctl <= 6'h04;
            settle();
            chk("termination", term_en, s == 0);
            pin_ctl <= 6'h20;
            settle();
            chk("termination", term_en, s == 1);
        end
        // status: only the termination enable is up, input six high
        rd(8'h20, d, r);
        chk("status", d, 32'h08);
        chk("status resp", {30'h0, r}, 32'h0);
        pin_ctl <= 6'h00;
        settle();
    endtask

    // load switch edges, on and off codes set differently
    task automatic s_ls_delay();
        int b_on, b_off, n;
        wr(IDX_B, 8'h00, 2'h0);
        wr(IDX_LS, 8'h00, 2'h0);
        @(posedge aclk);
        pin_ctl <= 6'h01;
        lat(0, 1'b1, b_on);
        pin_ctl <= 6'h00;
        lat(0, 1'b0, b_off);
        for (int c = 1; c < 8; c++) begin
            wr(IDX_LS, {2'b00, 3'(7 - c), 3'(c)}, 2'h0);
            @(posedge aclk);
            pin_ctl <= 6'h01;
            lat(0, 1'b1, n);
            chk("switch on delay", n, b_on + MS[c] * TICK);
            pin_ctl <= 6'h00;
            lat(0, 1'b0, n);
            chk("switch off delay", n, b_off + MS[7 - c] * TICK);
        end
    endtask

    // rail six edges, then a withdrawn edge restarts the count
    task automatic s_six_delay();
        int n;
        for (int c = 0; c < 8; c++) begin
            wr(IDX_SIX, {2'b00, 3'(7 - c), 3'(c)}, 2'h0);
            @(posedge aclk);
            six_req <= 1'b1;
            lat(1, 1'b1, n);
            chk("six on delay", n, MS[c] * TICK + 1);
            six_req <= 1'b0;
            lat(1, 1'b0, n);
            chk("six off delay", n, MS[7 - c] * TICK + 1);
        end
        wr(IDX_SIX, 8'h01, 2'h0);
        @(posedge aclk);
        six_req <= 1'b1;
        repeat (5) @(posedge aclk);
        six_req <= 1'b0;
        repeat (12) @(posedge aclk);
        #1;
        chk("six withdrawn", six_en, 1'b0);
        six_req <= 1'b1;
        lat(1, 1'b1, n);
        chk("six restart", n, MS[1] * TICK + 1);
    endtask

    // hang guard, well past the expected run
    initial begin
        #400000;
        err_count++;
        complete_run();
    end

    // main sequence
    initial begin
        err_count = 0;
        n_tests = 0;
        aresetn = 1'b0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready, six_req} = '0;
        pin_ctl = 6'h00;
        pin_good = 10'h3FF;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_regs();
        s_source();
        s_mask();
        s_misc();
        s_ls_delay();
        s_six_delay();
        complete_run();
    end
endmodule
